// ===== inc/cpdr_defs.svh
`ifndef CPDR_DEFS_SVH
`define CPDR_DEFS_SVH

// Register byte offsets
`define CPDR_CTRL_OFS          8'h00
`define CPDR_ASYNC_CLEAR_OFS   8'h04
`define CPDR_ASYNC_PRESET_OFS  8'h08
`define CPDR_SYNC_CLEAR_OFS    8'h0C
`define CPDR_SYNC_PRESET_OFS   8'h10
`define CPDR_STATUS_OFS        8'h14

// Control field positions
`define CPDR_CTRL_EDGE_BIT     0
`define CPDR_CTRL_LOAD_BIT     1
`define CPDR_CTRL_SRLVL_BIT    2
`define CPDR_CTRL_MSB          2

// Reset values
`define CPDR_CTRL_RST          3'h6
`define CPDR_INITIAL_RST       32'h0000_0000
`define CPDR_ASYNC_CLEAR_RST   32'h0000_0000
`define CPDR_ASYNC_PRESET_RST  32'hFFFF_FFFF
`define CPDR_SYNC_CLEAR_RST    32'h0000_0000
`define CPDR_SYNC_PRESET_RST   32'hFFFF_FFFF

// Bus answers
`define CPDR_RESP_OKAY         2'h0
`define CPDR_RESP_SLVERR       2'h2

// Timing count and width limit
`define CPDR_SYNC_FILL         2'h3
`define CPDR_MAX_WIDTH         32

`endif

// ===== inc/cpdr_pkg.sv
package cpdr_pkg;

   typedef enum logic {
      EDGE_RISE,
      EDGE_FALL
   } edge_sel_e;

   typedef struct packed {
      logic      sr_level;
      logic      load_level;
      edge_sel_e clock_edge_select;
   } ctrl_s;

   typedef logic [7:0] axi_addr_t;

endpackage : cpdr_pkg

// ===== core/cpdr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cpdr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s st;
   sync_s next_st;

   if (WIDTH < 1) begin : g_bad_width
      $error("cpdr_sync: WIDTH must be at least 1");
   end

   always_comb begin
      next_st        = st;
      next_st.meta   = i_async;
      next_st.stable = st.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_sync = st.stable;

endmodule : cpdr_sync

`default_nettype wire

// ===== core/cpdr_data_register.sv
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

`include "cpdr_defs.svh"

// Overview of operation
// - Load and sync clear/preset act only on the selected register clock edge, rising or falling.
// - Capture data on an active edge only while load is at its level.
// - Data input and output are register_width bits, one storage bit each.
// - Outputs hold initial_value after start, before any clock or set/reset.
// - Async clear or preset loads its own value without a clock edge.
// - Sync clear or preset loads its own value on an active edge.
// - All set and reset pins follow the configured polarity level.
module cpdr_data_register #(
   parameter int          REGISTER_WIDTH     = 8,
   parameter logic [31:0] INITIAL_VALUE      = `CPDR_INITIAL_RST,
   parameter logic [31:0] ASYNC_CLEAR_VALUE  = `CPDR_ASYNC_CLEAR_RST,
   parameter logic [31:0] ASYNC_PRESET_VALUE = `CPDR_ASYNC_PRESET_RST,
   parameter logic [31:0] SYNC_CLEAR_VALUE   = `CPDR_SYNC_CLEAR_RST,
   parameter logic [31:0] SYNC_PRESET_VALUE  = `CPDR_SYNC_PRESET_RST
) (
   input  wire logic                      I_CLK,
   input  wire logic                      I_RST_B,
   input  wire cpdr_pkg::axi_addr_t       I_AWADDR,
   input  wire logic                      I_AWVALID,
   output logic                           O_AWREADY,
   input  wire logic [31:0]               I_WDATA,
   input  wire logic [3:0]                I_WSTRB,
   input  wire logic                      I_WVALID,
   output logic                           O_WREADY,
   output logic [1:0]                     O_BRESP,
   output logic                           O_BVALID,
   input  wire logic                      I_BREADY,
   input  wire cpdr_pkg::axi_addr_t       I_ARADDR,
   input  wire logic                      I_ARVALID,
   output logic                           O_ARREADY,
   output logic [31:0]                    O_RDATA,
   output logic [1:0]                     O_RRESP,
   output logic                           O_RVALID,
   input  wire logic                      I_RREADY,
   input  wire logic                      I_REG_CLK,
   input  wire logic                      I_LOAD,
   input  wire logic [REGISTER_WIDTH-1:0] I_D,
   input  wire logic                      I_ASYNC_CLEAR,
   input  wire logic                      I_ASYNC_PRESET,
   input  wire logic                      I_SYNC_CLEAR,
   input  wire logic                      I_SYNC_PRESET,
   output logic      [REGISTER_WIDTH-1:0] O_Q
);

   import cpdr_pkg::*;

   localparam int W  = REGISTER_WIDTH;
   localparam int SW = W + 6;

   typedef struct packed {
      ctrl_s       ctrl;
      logic [W-1:0] async_clear_value;
      logic [W-1:0] async_preset_value;
      logic [W-1:0] sync_clear_value;
      logic [W-1:0] sync_preset_value;
      logic [W-1:0] q;
      logic         clk_prev;
      logic [1:0]   warm;
      logic         aw_got;
      logic         w_got;
      axi_addr_t    waddr;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         awready;
      logic         wready;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         arready;
      logic         rvalid;
      logic [1:0]   rresp;
      logic [31:0]  rdata;
   } state_s;

   localparam state_s RST_ST = '{
      ctrl:               ctrl_s'(`CPDR_CTRL_RST),
      async_clear_value:  ASYNC_CLEAR_VALUE[W-1:0],
      async_preset_value: ASYNC_PRESET_VALUE[W-1:0],
      sync_clear_value:   SYNC_CLEAR_VALUE[W-1:0],
      sync_preset_value:  SYNC_PRESET_VALUE[W-1:0],
      q:                  INITIAL_VALUE[W-1:0],
      clk_prev:           1'b0,
      warm:               2'h0,
      aw_got:             1'b0,
      w_got:              1'b0,
      waddr:              8'h00,
      wdata:              32'h0000_0000,
      wstrb:              4'h0,
      awready:            1'b1,
      wready:             1'b1,
      bvalid:             1'b0,
      bresp:              `CPDR_RESP_OKAY,
      arready:            1'b1,
      rvalid:             1'b0,
      rresp:              `CPDR_RESP_OKAY,
      rdata:              32'h0000_0000
   };

   if (W < 1 || W > `CPDR_MAX_WIDTH) begin : g_bad_width
      $error("cpdr_data_register: REGISTER_WIDTH must be 1 to 32");
   end

   state_s          st;
   state_s          next_st;
   logic [SW-1:0]   pins_raw;
   logic [SW-1:0]   pins;
   logic            s_clk;
   logic            s_load;
   logic            s_async_clear;
   logic            s_async_preset;
   logic            s_sync_clear;
   logic            s_sync_preset;
   logic [W-1:0]    s_d;
   logic            primed;
   logic            active_edge;
   logic [31:0]     merged;

   // Pins come from foreign logic, so every one is synchronised
   assign pins_raw = {I_REG_CLK, I_LOAD, I_ASYNC_CLEAR, I_ASYNC_PRESET,
                      I_SYNC_CLEAR, I_SYNC_PRESET, I_D};

   cpdr_sync #(
      .WIDTH   (SW)
   ) u_pin_sync (
      .i_clk   (I_CLK),
      .i_rst_b (I_RST_B),
      .i_async (pins_raw),
      .o_sync  (pins)
   );

   assign {s_clk, s_load, s_async_clear, s_async_preset,
           s_sync_clear, s_sync_preset, s_d} = pins;

   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_word[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   function automatic axi_addr_t word_addr(input axi_addr_t a);
      return {a[7:2], 2'b00};
   endfunction : word_addr

   always_comb begin
      next_st     = st;
      merged      = 32'h0000_0000;
      // Synchroniser output is junk until both stages are filled
      primed      = (st.warm == `CPDR_SYNC_FILL);
      active_edge = 1'b0;
      if (!primed) begin
         next_st.warm = st.warm + 2'h1;
      end
      next_st.clk_prev = s_clk;

      if (st.ctrl.clock_edge_select == EDGE_FALL) begin
         active_edge = primed && st.clk_prev && !s_clk;
      end else begin
         active_edge = primed && !st.clk_prev && s_clk;
      end

      // Clear checked before preset in each class
      if (primed && s_async_clear == st.ctrl.sr_level) begin
         next_st.q = st.async_clear_value;
      end else if (primed && s_async_preset == st.ctrl.sr_level) begin
         next_st.q = st.async_preset_value;
      end else if (active_edge) begin
         if (s_sync_clear == st.ctrl.sr_level) begin
            next_st.q = st.sync_clear_value;
         end else if (s_sync_preset == st.ctrl.sr_level) begin
            next_st.q = st.sync_preset_value;
         end else if (s_load == st.ctrl.load_level) begin
            next_st.q = s_d;
         end
      end

      if (I_AWVALID && st.awready) begin
         next_st.aw_got = 1'b1;
         next_st.waddr  = I_AWADDR;
      end
      if (I_WVALID && st.wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = I_WDATA;
         next_st.wstrb = I_WSTRB;
      end
      if (st.bvalid && I_BREADY) begin
         next_st.bvalid = 1'b0;
      end

      if (st.aw_got && st.w_got) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = `CPDR_RESP_OKAY;
         case (word_addr(st.waddr))
            `CPDR_CTRL_OFS: begin
               merged = merge_bytes(32'(st.ctrl), st.wdata, st.wstrb);
               next_st.ctrl = ctrl_s'(merged[`CPDR_CTRL_MSB:0]);
            end
            `CPDR_ASYNC_CLEAR_OFS: begin
               merged = merge_bytes(32'(st.async_clear_value), st.wdata,
                                    st.wstrb);
               next_st.async_clear_value = merged[W-1:0];
            end
            `CPDR_ASYNC_PRESET_OFS: begin
               merged = merge_bytes(32'(st.async_preset_value), st.wdata,
                                    st.wstrb);
               next_st.async_preset_value = merged[W-1:0];
            end
            `CPDR_SYNC_CLEAR_OFS: begin
               merged = merge_bytes(32'(st.sync_clear_value), st.wdata,
                                    st.wstrb);
               next_st.sync_clear_value = merged[W-1:0];
            end
            `CPDR_SYNC_PRESET_OFS: begin
               merged = merge_bytes(32'(st.sync_preset_value), st.wdata,
                                    st.wstrb);
               next_st.sync_preset_value = merged[W-1:0];
            end
            // Read-only, write is dropped but still acknowledged
            `CPDR_STATUS_OFS: begin
               merged = 32'h0000_0000;
            end
            default: begin
               next_st.bresp = `CPDR_RESP_SLVERR;
            end
         endcase
      end

      if (st.rvalid && I_RREADY) begin
         next_st.rvalid = 1'b0;
      end
      if (I_ARVALID && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = `CPDR_RESP_OKAY;
         case (word_addr(I_ARADDR))
            `CPDR_CTRL_OFS: begin
               next_st.rdata = 32'(st.ctrl);
            end
            `CPDR_ASYNC_CLEAR_OFS: begin
               next_st.rdata = 32'(st.async_clear_value);
            end
            `CPDR_ASYNC_PRESET_OFS: begin
               next_st.rdata = 32'(st.async_preset_value);
            end
            `CPDR_SYNC_CLEAR_OFS: begin
               next_st.rdata = 32'(st.sync_clear_value);
            end
            `CPDR_SYNC_PRESET_OFS: begin
               next_st.rdata = 32'(st.sync_preset_value);
            end
            `CPDR_STATUS_OFS: begin
               next_st.rdata = 32'(st.q);
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = `CPDR_RESP_SLVERR;
            end
         endcase
      end

      // One write and one read in flight at most
      next_st.awready = !next_st.aw_got && !next_st.bvalid;
      next_st.wready  = !next_st.w_got && !next_st.bvalid;
      next_st.arready = !next_st.rvalid;
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st <= RST_ST;
      end else begin
         st <= next_st;
      end
   end

   assign O_AWREADY = st.awready;
   assign O_WREADY  = st.wready;
   assign O_BRESP   = st.bresp;
   assign O_BVALID  = st.bvalid;
   assign O_ARREADY = st.arready;
   assign O_RDATA   = st.rdata;
   assign O_RRESP   = st.rresp;
   assign O_RVALID  = st.rvalid;
   assign O_Q       = st.q;

endmodule : cpdr_data_register

`default_nettype wire

// ===== verification/cpdr_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpdr_defs.svh"
module cpdr_properties #(
   parameter int          REGISTER_WIDTH = 8,
   parameter logic [31:0] INITIAL_VALUE  = 32'h0
) (
   input wire logic                      I_CLK,
   input wire logic                      I_RST_B,
   input wire cpdr_pkg::axi_addr_t       I_AWADDR,
   input wire logic                      I_AWVALID,
   input wire logic                      O_AWREADY,
   input wire logic [31:0]               I_WDATA,
   input wire logic [3:0]                I_WSTRB,
   input wire logic                      I_WVALID,
   input wire logic                      O_WREADY,
   input wire logic                      O_BVALID,
   input wire logic                      I_ARVALID,
   input wire logic                      O_ARREADY,
   input wire logic                      O_RVALID,
   input wire logic                      I_REG_CLK,
   input wire logic                      I_LOAD,
   input wire logic [REGISTER_WIDTH-1:0] I_D,
   input wire logic                      I_ASYNC_CLEAR,
   input wire logic                      I_ASYNC_PRESET,
   input wire logic                      I_SYNC_CLEAR,
   input wire logic                      I_SYNC_PRESET,
   input wire logic [REGISTER_WIDTH-1:0] O_Q
);
   import cpdr_pkg::*;
   localparam int W = REGISTER_WIDTH;
   logic [31:0] rv [5];
   logic [1:0]  n;
   logic        pc;
   wire lv  = rv[0][2];
   wire ac  = I_ASYNC_CLEAR == lv;
   wire ap  = I_ASYNC_PRESET == lv;
   wire sc  = I_SYNC_CLEAR == lv;
   wire sp  = I_SYNC_PRESET == lv;
   wire ld  = I_LOAD == rv[0][1];
   wire hit = pc != I_REG_CLK && I_REG_CLK != rv[0][0];
   wire wr  = I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
   // Partial writes skipped; the bench aims them at lanes above the width
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rv <= '{`CPDR_CTRL_RST, `CPDR_ASYNC_CLEAR_RST, `CPDR_ASYNC_PRESET_RST,
                 `CPDR_SYNC_CLEAR_RST, `CPDR_SYNC_PRESET_RST};
         n  <= 2'h0;
         pc <= 1'b0;
      end else begin
         if (wr && I_AWADDR < 8'h14 && I_WSTRB == 4'hF)
            rv[I_AWADDR[4:2]] <= I_WDATA;
         if (n != 2'h3)
            n <= n + 2'h1;
         pc <= I_REG_CLK;
      end
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   sequence s_load;
      (ld && !ac && !ap && !sc && !sp && $stable(I_D))[*4];
   endsequence
   sequence s_sclr;
      (sc && !ac && !ap)[*4];
   endsequence
   a_b_timing: assert property (wr |=> !O_BVALID ##1 O_BVALID)
      else $error("write answer late or early");
   a_ready_low: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
      else $error("write taken while answer pending");
   a_r_timing: assert property (I_ARVALID && O_ARREADY
                                |=> O_RVALID && !O_ARREADY)
      else $error("read answer not next cycle");
   a_init_hold: assert property (
         n < 2'h2 |-> O_Q == INITIAL_VALUE[W-1:0])
      else $error("initial value not held");
   a_aclr_wins: assert property (
         ac[*4] |-> O_Q == rv[1][W-1:0])
      else $error("async clear value missing");
   a_apre_value: assert property (
         (ap && !ac)[*4] |-> O_Q == rv[2][W-1:0])
      else $error("async preset value missing");
   a_sclr_value: assert property (
         hit ##0 s_sclr |-> O_Q == rv[3][W-1:0])
      else $error("sync clear value missing");
   a_load_capt: assert property (
         hit ##0 s_load |-> O_Q == I_D)
      else $error("data not captured");
endmodule : cpdr_properties
bind cpdr_data_register cpdr_properties #(
   .REGISTER_WIDTH(REGISTER_WIDTH), .INITIAL_VALUE(INITIAL_VALUE)
) props (
   .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_AWADDR(I_AWADDR), .I_WDATA(I_WDATA),
   .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WSTRB(I_WSTRB),
   .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .O_Q(O_Q),
   .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
   .I_REG_CLK(I_REG_CLK), .I_LOAD(I_LOAD), .I_D(I_D),
   .I_ASYNC_CLEAR(I_ASYNC_CLEAR), .I_ASYNC_PRESET(I_ASYNC_PRESET),
   .I_SYNC_CLEAR(I_SYNC_CLEAR), .I_SYNC_PRESET(I_SYNC_PRESET)
);
`default_nettype wire

// ===== verification/cpdr_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cpdr_pin_partner (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_go,
   input  wire logic [3:0] i_hold,
   output logic            o_reg_clk
);
   logic [3:0] cnt;
   logic       pend;
   // Flip after a chosen delay; clock stands still between requests
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_clk <= 1'b0;
         cnt       <= 4'h0;
         pend      <= 1'b0;
      end else if (i_go) begin
         pend <= 1'b1;
         cnt  <= i_hold;
      end else if (pend && cnt == 4'h0) begin
         pend      <= 1'b0;
         o_reg_clk <= !o_reg_clk;
      end else if (pend) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule : cpdr_pin_partner
`default_nettype wire

// ===== verification/configurable_parallel_data_register_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module configurable_parallel_data_register_tb_top;
   import cpdr_pkg::*;
   logic        clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
   logic        arv = 1'b0, rr = 1'b0, ld = 1'b0, go = 1'b0, rk = 1'b0;
   logic        ac = 1'b0, ap = 1'b0, sc = 1'b0, sp = 1'b0;
   logic        rck, awr, wrd, bv, arr, rvl;
   logic [1:0]  bre, rre;
   logic [3:0]  hold = 4'h0, ws = 4'h0;
   logic [7:0]  d = 8'h00, q;
   logic [31:0] wd = 32'h0, rdt, v, seed = 32'hD25B3252;
   logic [31:0] rm [5];
   axi_addr_t   aw = 8'h00, ar = 8'h00;
   int          n_fail = 0, compares = 0, qm = 0;
   int          pats [6] = '{8, 0, 0, 3, 1, 0};
   always #2 clk = !clk;
   cpdr_data_register dut (
      .I_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(aw), .I_AWVALID(awv),
      .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv),
      .O_WREADY(wrd), .O_BRESP(bre), .O_BVALID(bv), .I_BREADY(br),
      .I_ARADDR(ar), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdt),
      .O_RRESP(rre), .O_RVALID(rvl), .I_RREADY(rr), .I_REG_CLK(rck),
      .I_LOAD(ld), .I_D(d), .I_ASYNC_CLEAR(ac), .I_ASYNC_PRESET(ap),
      .I_SYNC_CLEAR(sc), .I_SYNC_PRESET(sp), .O_Q(q));
   cpdr_pin_partner far (.i_clk(clk), .i_rst_b(rst_b), .i_go(go),
      .i_hold(hold), .o_reg_clk(rck));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic finish_test();
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input axi_addr_t a, input logic [31:0] x,
                     input logic [3:0] s, input logic [1:0] r);
      aw <= a; wd <= x; ws <= s; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      fork
         begin do @(posedge clk); while (!awr); awv <= 1'b0; end
         begin do @(posedge clk); while (!wrd); wv <= 1'b0; end
      join
      while (!bv) @(posedge clk);
      br <= 1'b0;
      chk("bresp", bre, r);
      @(posedge clk);
   endtask : wr
   task automatic rd(input axi_addr_t a, input logic [31:0] e,
                     input logic [1:0] r);
      ar <= a; arv <= 1'b1; rr <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rvl);
      rr <= 1'b0;
      chk("rdata", rdt, e);
      chk("rresp", rre, r);
      @(posedge clk);
   endtask : rd
   // One register clock flip with pins and data set a random 2 to 17 cycles ahead
   task automatic step(input logic [3:0] p);
      logic [31:0] r;
      r = rnd();
      {ac, ap, sc, sp} <= p ^ {4{!rm[0][2]}};
      d <= r[7:0]; ld <= r[8]; hold <= r[12:9]; go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (r[12:9] + 8) @(posedge clk);
      rk = !rk;
      if (p[3]) qm = rm[1];
      else if (p[2]) qm = rm[2];
      else if (rk != rm[0][0]) begin
         if (p[1]) qm = rm[3];
         else if (p[0]) qm = rm[4];
         else if (r[8] == rm[0][1]) qm = r[7:0];
      end
      chk("q", q, qm);
      rd(8'h14, qm, 2'h0);
   endtask : step
   initial begin
      rm = '{32'h6, 32'h0, 32'hFF, 32'h0, 32'hFF};
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("q", q, 0);
      for (int i = 0; i < 5; i++) rd(axi_addr_t'(i * 4), rm[i], 2'h0);
      rd(8'h20, 0, 2'h2);
      wr(8'h20, rnd(), 4'hF, 2'h2);
      wr(8'h14, rnd(), 4'hF, 2'h0);
      for (int i = 1; i < 5; i++) begin
         v = rnd();
         rm[i] = v & 32'hFF;
         wr(axi_addr_t'(i * 4), v, 4'hF, 2'h0);
         // Upper lanes only: nothing above the width is stored
         wr(axi_addr_t'(i * 4), ~v, 4'hE, 2'h0);
         rd(axi_addr_t'(i * 4), rm[i], 2'h0);
      end
      for (int m = 0; m < 8; m++) begin
         rm[0] = m;
         pats[5] = int'(rnd() & 32'hF);
         wr(8'h00, m, 4'hF, 2'h0);
         for (int e = 0; e < 6; e++) step(4'(pats[e]));
      end
      {ac, ap, sc, sp} <= 4'h0;
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("q", q, 0);
      rd(8'h00, 32'h6, 2'h0);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      finish_test();
   end
endmodule : configurable_parallel_data_register_tb_top
`default_nettype wire
